// ===== hw/acs_sequencer.sv
`timescale 1ns/1ns
// Operation
// RQ1 - equal sequencer bits convert selected single channel
// RQ2 - list mode converts flagged channels, ascending
// RQ3 - list repeats and wraps until control write
// RQ4 - sequences apply each channel's stored range
// RQ5 - consecutive mode runs channel 0 to final
// RQ6 - sequence register holds one include flag per channel
// RQ7 - sequence word: write, select, flags at 13..6
// RQ8 - low range register: channels 0-3, two bits each
// RQ9 - host writes low range with select 01
// RQ10 - high range register: channels 4-7, same layout
// RQ11 - each selection applies stored range code
// RQ12 - all ranges reset to plus minus ten volts
// RQ13 - range code 00/01/10/11 decodes to four ranges
// RQ14 - channel select bits at word bits 12..10
// RQ15 - sequencer bits at word bits 3 and 2
// RQ16 - four registers have distinct select codes
// RQ17 - write flag zero leaves registers unchanged
module acs_sequencer
    import acs_pkg::*;
(
    input  wire logic     mclk,      // system clock, 100 MHz
    input  wire logic     rst,       // synchronous reset, high
    input  wire logic     ce,        // clock enable, freezes all state
    input  wire logic     csN,       // frame select pin, low active
    input  wire logic     sclk,      // serial clock pin
    input  wire logic     din,       // serial data pin
    output acs_pkg::acsConv_t conv,  // channel and range of this conversion
    output logic          convStart, // pulse per frame, conversion begins
    output logic          seqActive  // a sequencer mode is armed
);
    import acs_pkg::*;

    logic     frameStart, wordValid;
    acsWord_t word;

    acs_serial_rx u_rx (
        .mclk       (mclk),
        .rst        (rst),
        .ce         (ce),
        .csN        (csN),
        .sclk       (sclk),
        .din        (din),
        .frameStart (frameStart),
        .wordValid  (wordValid),
        .word       (word)
    );

    logic [CHAN_W-1:0]   ctrlChan_q, ctrlChan_d;
    logic [NUM_CHAN-1:0] seqChannelFlags_q, seqChannelFlags_d, payloadRev;
    logic [7:0]          rangeCodesLow_q, rangeCodesLow_d;
    logic [7:0]          rangeCodesHigh_q, rangeCodesHigh_d;
    acsSeqState_t        state_q, state_d;
    logic                restart_q, restart_d;
    acsConv_t            conv_q, conv_d;
    logic                convStart_q, convStart_d, seqActive_q, seqActive_d;
    logic [CHAN_W-1:0]   nextChan;
    logic                sequencerCtrlHi, sequencerCtrlLo;

    // channel 0 flag arrives first, so the payload is bit reversed
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++)
        begin : g_rev
            assign payloadRev[gi] = word.payload[NUM_CHAN-1-gi]; // [RQ6] [RQ7]
        end
    endgenerate

    assign sequencerCtrlHi = word.tail[SEQUENCER_CTRL_HI_POS];
    assign sequencerCtrlLo = word.tail[SEQUENCER_CTRL_LO_POS];

    // two range bits per channel, lowest channel in the top pair
    function automatic logic [RANGE_W-1:0] rangeOf(
        input logic [CHAN_W-1:0] ch,
        input logic [7:0]        low,
        input logic [7:0]        high
    );
        logic [7:0] sh;
        sh = (ch[2] ? high : low) << {ch[1:0], 1'b0};
        return sh[7:6];
    endfunction

    function automatic acsRangeSel_t decodeRange(input logic [RANGE_W-1:0] code);
        case (code)
            2'h0:    return RANGE_PM10;
            2'h1:    return RANGE_PM5;
            2'h2:    return RANGE_PM2P5;
            2'h3:    return RANGE_UNI10;
            default: return RANGE_PM10;
        endcase
    endfunction

    function automatic logic [CHAN_W-1:0] lowestFlag(input logic [NUM_CHAN-1:0] f);
        logic [CHAN_W-1:0] low;
        low = CTRL_CHAN_RST;
        for (int i = NUM_CHAN - 1; i >= 0; i--)
        begin
            if (f[i])
                low = CHAN_W'(i);
        end
        return low;
    endfunction

    // lowest flagged channel above cur, else wrap to lowest flagged
    function automatic logic [CHAN_W-1:0] nextFlagged(
        input logic [NUM_CHAN-1:0] f,
        input logic [CHAN_W-1:0]   cur,
        input logic                first
    );
        logic [CHAN_W-1:0] up;
        logic              foundUp;
        up      = CTRL_CHAN_RST;
        foundUp = 1'b0;
        for (int i = NUM_CHAN - 1; i >= 0; i--)
        begin
            if (f[i] && !first && (CHAN_W'(i) > cur))
            begin
                up      = CHAN_W'(i);
                foundUp = 1'b1;
            end
        end
        return foundUp ? up : lowestFlag(f);
    endfunction

    // channel picked for the conversion that a new frame starts
    always_comb
    begin
        case (state_q)
            ST_SINGLE:
                nextChan = ctrlChan_q;                                    // [RQ1]
            ST_LIST:
                nextChan = (seqChannelFlags_q == SEQ_FLAGS_RST) ? ctrlChan_q
                         : nextFlagged(seqChannelFlags_q, conv_q.chan, restart_q); // [RQ2] [RQ3]
            ST_CONSEC:
                nextChan = (restart_q || conv_q.chan >= ctrlChan_q) ? CTRL_CHAN_RST
                         : conv_q.chan + 3'h1;                            // [RQ5]
            default:
                nextChan = ctrlChan_q;
        endcase
    end

    // register writes and conversion stepping
    always_comb
    begin
        ctrlChan_d        = ctrlChan_q;
        seqChannelFlags_d = seqChannelFlags_q;
        rangeCodesLow_d   = rangeCodesLow_q;
        rangeCodesHigh_d  = rangeCodesHigh_q;
        state_d           = state_q;
        restart_d         = restart_q;
        conv_d            = conv_q;
        convStart_d       = 1'b0;
        if (frameStart)
        begin
            conv_d.chan  = nextChan;
            conv_d.range = rangeOf(nextChan, rangeCodesLow_q, rangeCodesHigh_q); // [RQ4] [RQ11]
            conv_d.sel   = decodeRange(conv_d.range);                     // [RQ13]
            convStart_d  = 1'b1;
            restart_d    = 1'b0;
        end
        // a read-only word does not touch any register
        if (wordValid && word.writeEn)                                    // [RQ17]
        begin
            case (word.regSel)                                            // [RQ16]
                REG_CONTROL:
                begin
                    ctrlChan_d = word.payload[CHAN_SEL_BIT2_POS:CHAN_SEL_BIT0_POS]; // [RQ14]
                    restart_d  = 1'b1;                                    // [RQ3]
                    case (acsSeqMode_t'({sequencerCtrlHi, sequencerCtrlLo})) // [RQ15]
                        MODE_LIST:   state_d = ST_LIST;                   // [RQ2]
                        MODE_CONSEC: state_d = ST_CONSEC;                 // [RQ5]
                        default:     state_d = ST_SINGLE;                 // [RQ1]
                    endcase
                end
                REG_SEQUENCE:
                begin
                    seqChannelFlags_d = payloadRev;                       // [RQ6] [RQ7]
                    restart_d         = 1'b1;
                end
                REG_RANGE_LOW:
                    rangeCodesLow_d = word.payload;                       // [RQ8] [RQ9]
                REG_RANGE_HIGH:
                    rangeCodesHigh_d = word.payload;                      // [RQ10]
                default:
                    ctrlChan_d = ctrlChan_q;
            endcase
        end
        seqActive_d = (state_d != ST_SINGLE);
    end

    // all registers hold while ce is low, outputs included
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrlChan_q        <= CTRL_CHAN_RST;
            seqChannelFlags_q <= SEQ_FLAGS_RST;
            rangeCodesLow_q   <= RANGE_RST;                               // [RQ12]
            rangeCodesHigh_q  <= RANGE_RST;                               // [RQ12]
            state_q           <= ST_SINGLE;
            restart_q         <= 1'b1;
            conv_q            <= '{chan: 3'h0, range: 2'h0, sel: RANGE_PM10};
            convStart_q       <= 1'b0;
            seqActive_q       <= 1'b0;
        end
        else if (ce)
        begin
            ctrlChan_q        <= ctrlChan_d;
            seqChannelFlags_q <= seqChannelFlags_d;
            rangeCodesLow_q   <= rangeCodesLow_d;
            rangeCodesHigh_q  <= rangeCodesHigh_d;
            state_q           <= state_d;
            restart_q         <= restart_d;
            conv_q            <= conv_d;
            convStart_q       <= convStart_d;
            seqActive_q       <= seqActive_d;
        end
    end

    assign conv      = conv_q;
    assign convStart = convStart_q;
    assign seqActive = seqActive_q;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    logic ctrlWrite, listStep;
    assign ctrlWrite = ce && wordValid && word.writeEn && (word.regSel == REG_CONTROL);
    assign listStep  = ce && frameStart && (state_q == ST_LIST)
                     && (seqChannelFlags_q != SEQ_FLAGS_RST);

    single_chan_a: assert property ( // [RQ1]
        ce && frameStart && state_q == ST_SINGLE
        |=> convStart_q && conv_q.chan == $past(ctrlChan_q))
        else $error("single mode converted the wrong channel");

    mode_single_a: assert property ( // [RQ15]
        ctrlWrite && (sequencerCtrlHi == sequencerCtrlLo)
        |=> state_q == ST_SINGLE && !seqActive_q)
        else $error("equal sequencer bits did not stop sequencing");

    list_first_a: assert property ( // [RQ2]
        listStep && restart_q |=> conv_q.chan == lowestFlag(seqChannelFlags_q))
        else $error("list did not start at lowest flagged channel");

    list_order_a: assert property ( // [RQ3]
        listStep && !restart_q
        |=> seqChannelFlags_q[conv_q.chan]
            && (conv_q.chan > $past(conv_q.chan)
                || conv_q.chan == lowestFlag(seqChannelFlags_q)))
        else $error("list step not ascending or not wrapped");

    consec_step_a: assert property ( // [RQ5]
        ce && frameStart && state_q == ST_CONSEC && !restart_q
        && conv_q.chan < ctrlChan_q
        |=> conv_q.chan == $past(conv_q.chan) + 3'h1)
        else $error("consecutive mode skipped a channel");

    consec_wrap_a: assert property ( // [RQ5]
        ce && frameStart && state_q == ST_CONSEC
        && (restart_q || conv_q.chan >= ctrlChan_q)
        |=> conv_q.chan == 3'h0)
        else $error("consecutive mode did not restart at channel 0");

    range_apply_a: assert property ( // [RQ11]
        convStart_q
        |-> conv_q.range == rangeOf(conv_q.chan, rangeCodesLow_q, rangeCodesHigh_q))
        else $error("conversion range differs from stored code");

    range_decode_a: assert property ( // [RQ13]
        convStart_q |-> conv_q.sel == acsRangeSel_t'(4'h1 << conv_q.range))
        else $error("range code decoded wrongly");

    write_gate_a: assert property ( // [RQ17]
        ce && wordValid && !word.writeEn
        |=> $stable(seqChannelFlags_q) && $stable(rangeCodesLow_q)
            && $stable(rangeCodesHigh_q))
        else $error("register changed without write flag");

    seq_write_a: assert property ( // [RQ7]
        ce && wordValid && word.writeEn && word.regSel == REG_SEQUENCE
        |=> seqChannelFlags_q[0] == $past(word.payload[7])
            && seqChannelFlags_q[7] == $past(word.payload[0]))
        else $error("sequence flags stored in wrong order");

    range_high_a: assert property ( // [RQ10]
        ce && wordValid && word.writeEn && word.regSel == REG_RANGE_HIGH
        |=> rangeCodesHigh_q == $past(word.payload) && $stable(rangeCodesLow_q))
        else $error("high range register write failed");

    range_reset_a: assert property ( // [RQ12]
        $past(rst) |-> rangeCodesLow_q == 8'h00 && rangeCodesHigh_q == 8'h00)
        else $error("range codes not at default after reset");

    list_wrap_c: cover property (listStep && !restart_q ##1
        conv_q.chan == lowestFlag(seqChannelFlags_q));
    consec_wrap_c: cover property (ce && frameStart && state_q == ST_CONSEC
        && !restart_q && conv_q.chan >= ctrlChan_q);
    range_low_c: cover property (ce && wordValid && word.writeEn
        && word.regSel == REG_RANGE_LOW);

endmodule

// ===== hw/acs_pkg.sv
package acs_pkg;

    // geometry of the converter front end
    localparam int NUM_CHAN = 8;
    localparam int CHAN_W   = 3;
    localparam int RANGE_W  = 2;
    localparam int WORD_W   = 16;

    // serial word as shifted in, first bit received is writeEn
    typedef struct packed {
        logic       writeEn;   // word bit 16
        logic [1:0] regSel;    // word bits 15..14
        logic [7:0] payload;   // word bits 13..6
        logic [4:0] tail;      // word bits 5..1
    } acsWord_t;

    // control fields inside the payload and tail
    localparam int CHAN_SEL_BIT0_POS    = 4;  // word bit 10 in payload
    localparam int CHAN_SEL_BIT2_POS    = 6;  // word bit 12 in payload
    localparam int SEQUENCER_CTRL_LO_POS = 1; // word bit 2 in tail
    localparam int SEQUENCER_CTRL_HI_POS = 2; // word bit 3 in tail

    // register select codes
    localparam logic [1:0] REG_CONTROL     = 2'h0;
    localparam logic [1:0] REG_RANGE_LOW   = 2'h1;
    localparam logic [1:0] REG_RANGE_HIGH  = 2'h2;
    localparam logic [1:0] REG_SEQUENCE    = 2'h3;

    // reset values and the bit count of a word
    localparam logic [7:0]        SEQ_FLAGS_RST = 8'h00;
    localparam logic [7:0]        RANGE_RST     = 8'h00;
    localparam logic [CHAN_W-1:0] CTRL_CHAN_RST = 3'h0;
    localparam logic [4:0]        BIT_COUNT_RST = 5'h00;
    localparam logic [4:0]        WORD_BITS     = 5'h10;

    typedef enum logic [1:0] {
        MODE_SINGLE_A = 2'h0,
        MODE_LIST     = 2'h1,
        MODE_CONSEC   = 2'h2,
        MODE_SINGLE_B = 2'h3
    } acsSeqMode_t;

    typedef enum logic [3:0] {
        RANGE_PM10  = 4'h1,
        RANGE_PM5   = 4'h2,
        RANGE_PM2P5 = 4'h4,
        RANGE_UNI10 = 4'h8
    } acsRangeSel_t;

    typedef enum logic [2:0] {
        ST_SINGLE = 3'h1,
        ST_LIST   = 3'h2,
        ST_CONSEC = 3'h4
    } acsSeqState_t;

    // conversion request handed to the analog front end
    typedef struct packed {
        logic [CHAN_W-1:0]  chan;
        logic [RANGE_W-1:0] range;
        acsRangeSel_t       sel;
    } acsConv_t;

endpackage

// ===== hw/acs_serial_rx.sv
`timescale 1ns/1ns
module acs_serial_rx
    import acs_pkg::*;
(
    input  wire logic     mclk,        // system clock
    input  wire logic     rst,         // synchronous reset, high
    input  wire logic     ce,          // clock enable
    input  wire logic     csN,         // frame select pin, low active
    input  wire logic     sclk,        // serial clock pin
    input  wire logic     din,         // serial data pin
    output logic          frameStart,  // pulse on frame select fall
    output logic          wordValid,   // pulse after the 16th bit
    output acs_pkg::acsWord_t word     // last complete word
);
    import acs_pkg::*;

    logic [1:0] csSync_q, csSync_d, sclkSync_q, sclkSync_d, dinSync_q, dinSync_d;
    logic       csLast_q, csLast_d, sclkLast_q, sclkLast_d;
    logic [4:0] count_q, count_d;
    logic [WORD_W-1:0] shift_q, shift_d;
    logic       frameStart_q, frameStart_d, wordValid_q, wordValid_d;
    acsWord_t   word_q, word_d;
    logic       sclkFall, csFall;

    // pins pass two flops; only the second stage feeds edge detection
    always_comb
    begin
        csSync_d     = {csSync_q[0], csN};
        sclkSync_d   = {sclkSync_q[0], sclk};
        dinSync_d    = {dinSync_q[0], din};
        csLast_d     = csSync_q[1];
        sclkLast_d   = sclkSync_q[1];
        sclkFall     = sclkLast_q & ~sclkSync_q[1];
        csFall       = csLast_q & ~csSync_q[1];
        count_d      = count_q;
        shift_d      = shift_q;
        word_d       = word_q;
        wordValid_d  = 1'b0;
        frameStart_d = csFall;
        if (csSync_q[1])
        begin
            count_d = BIT_COUNT_RST;                    // a short frame is discarded
        end
        else if (sclkFall && (count_q < WORD_BITS))
        begin
            shift_d = {shift_q[WORD_W-2:0], dinSync_q[1]}; // msb first [RQ7]
            count_d = count_q + 5'h01;
            if (count_q == WORD_BITS - 5'h01)
            begin
                word_d      = acsWord_t'({shift_q[WORD_W-2:0], dinSync_q[1]});
                wordValid_d = 1'b1;
            end
        end
    end

    // idle levels are high so reset never fakes an edge
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            csSync_q     <= 2'h3;
            sclkSync_q   <= 2'h3;
            dinSync_q    <= 2'h0;
            csLast_q     <= 1'b1;
            sclkLast_q   <= 1'b1;
            count_q      <= BIT_COUNT_RST;
            shift_q      <= 16'h0000;
            word_q       <= 16'h0000;
            frameStart_q <= 1'b0;
            wordValid_q  <= 1'b0;
        end
        else if (ce)
        begin
            csSync_q     <= csSync_d;
            sclkSync_q   <= sclkSync_d;
            dinSync_q    <= dinSync_d;
            csLast_q     <= csLast_d;
            sclkLast_q   <= sclkLast_d;
            count_q      <= count_d;
            shift_q      <= shift_d;
            word_q       <= word_d;
            frameStart_q <= frameStart_d;
            wordValid_q  <= wordValid_d;
        end
    end

    assign frameStart = frameStart_q;
    assign wordValid  = wordValid_q;
    assign word       = word_q;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    rx_frame_gap_a: assert property (wordValid_q |-> !frameStart_q) // [RQ7]
        else $error("word and frame start in the same cycle");

endmodule

// ===== bench/acs_host_model.sv
`timescale 1ns/1ns
// host side of the serial control port; every pin moves just after mclk rises
module acs_host_model
(
    input  wire logic mclk,  // system clock
    output logic      csN,   // frame select, low active
    output logic      sclk,  // serial clock, stands high between frames
    output logic      din    // serial data, msb first
);
    initial
    begin
        csN  = 1'b1;
        sclk = 1'b1;
        din  = 1'b0;
    end

    // shifts nBits of a word; din moves on the rising sclk edge so that
    // the falling-edge sample always sees a settled bit
    task automatic send_word(input logic [15:0] w, input int nBits);
        begin
            @(posedge mclk);
            csN <= 1'b0;
            repeat (5) @(posedge mclk);  // lead time before the first fall
            for (int i = 15; i > 15 - nBits; i--)
            begin
                din <= w[i];
                repeat (4) @(posedge mclk);
                sclk <= 1'b0;
                repeat (4) @(posedge mclk);
                sclk <= 1'b1;
            end
            repeat (4) @(posedge mclk);
            csN <= 1'b1;
            din <= ~din;  // a released line must not look like held data
        end
    endtask
endmodule

// ===== bench/acs_sequencer_bench.sv
`timescale 1ns/1ns
module acs_sequencer_bench;
    import acs_pkg::*;

    logic     mclk;
    logic     rst;
    logic     ce;
    logic     csN;
    logic     sclk;
    logic     din;
    acsConv_t conv;
    logic     convStart;
    logic     seqActive;
    int       nErrors;
    int       checkCount;
    // reference model state, plain integers
    int       rng[8];
    int       flags;
    int       cchan;
    int       mode;
    int       cur;
    bit       restart;

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    acs_sequencer acs_sequencer_i (
        .mclk      (mclk),
        .rst       (rst),
        .ce        (ce),
        .csN       (csN),
        .sclk      (sclk),
        .din       (din),
        .conv      (conv),
        .convStart (convStart),
        .seqActive (seqActive)
    );

    acs_host_model acs_host_model_i (
        .mclk (mclk),
        .csN  (csN),
        .sclk (sclk),
        .din  (din)
    );

    task automatic finish_test();
        begin
            if (nErrors == 0 && checkCount > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    task automatic check_conv(input acsConv_t exp);
        begin
            checkCount++;
            if (conv !== exp)
            begin
                nErrors++;
                $display("[FAIL] conv expected %h seen %h", exp, conv);
            end
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic seen);
        begin
            checkCount++;
            if (seen !== exp)
            begin
                nErrors++;
                $display("[FAIL] %s expected %b seen %b", name, exp, seen);
            end
        end
    endtask

    function automatic logic [15:0] mk_word(logic [1:0] sel, logic [7:0] pay, logic [4:0] t);
        return {1'b1, sel, pay, t};
    endfunction

    // model back to power-up state, mirrors the design's reset values
    task automatic model_reset();
        begin
            flags = 0;
            cchan = 0;
            mode = 0;
            cur = 0;
            restart = 1'b1;
            foreach (rng[i]) rng[i] = 0;
        end
    endtask

    // channel of the conversion that the next frame starts
    function automatic int predict();
        int ch;
        ch = cchan;
        if (mode == 1 && flags != 0)
        begin
            ch = restart ? -1 : cur;
            do ch = (ch + 1) % 8; while (!flags[ch]);
        end
        else if (mode == 2)
            ch = (restart || cur >= cchan) ? 0 : cur + 1;
        restart = 1'b0;
        cur = ch;
        return ch;
    endfunction

    // register effect of a complete word
    task automatic apply(input logic [15:0] w);
        begin
            if (!w[15])
                return;
            case (w[14:13])
                2'h0:
                begin
                    cchan = w[11:9];
                    mode = w[2:1];
                    restart = 1'b1;
                end
                2'h1: for (int i = 0; i < 4; i++) rng[i] = w[12-2*i -: 2];
                2'h2: for (int i = 0; i < 4; i++) rng[4+i] = w[12-2*i -: 2];
                default:
                begin
                    for (int i = 0; i < 8; i++) flags[i] = w[12-i];
                    restart = 1'b1;
                end
            endcase
        end
    endtask

    // waits for the start pulse, bounded, then checks it against the model
    task automatic wait_start(input acsConv_t exp, input logic expAct);
        int t;
        begin
            t = 0;
            while (convStart !== 1'b1 && t < 40)
            begin
                @(negedge mclk);
                t++;
            end
            check_bit("convStart", 1'b1, convStart);
            check_conv(exp);
            check_bit("seqActive", expAct, seqActive);
            @(negedge mclk);
            check_bit("convStart", 1'b0, convStart);
        end
    endtask

    task automatic frame(input logic [15:0] w, input int nBits);
        acsConv_t exp;
        logic     expAct;
        int       ch;
        begin
            expAct = (mode == 1 || mode == 2);
            ch = predict();
            exp.chan = ch[2:0];
            exp.range = rng[ch][1:0];
            exp.sel = acsRangeSel_t'(4'h1 << rng[ch]);
            fork
                acs_host_model_i.send_word(w, nBits);
                wait_start(exp, expAct);
            join
            if (nBits == 16)
                apply(w);
            repeat (8) @(posedge mclk);
            // idle clock-enable drops must not disturb anything
            if ($urandom_range(0, 3) == 0)
            begin
                ce <= 1'b0;
                repeat (3) @(posedge mclk);
                ce <= 1'b1;
            end
            @(posedge mclk);
        end
    endtask

    initial
    begin
        logic [7:0] seqW;
        logic [1:0] rsel;
        rst = 1'b1;
        ce = 1'b1;
        nErrors = 0;
        checkCount = 0;
        model_reset();
        void'($urandom(32'h0d8ed03c));
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        frame(16'h0000, 16);
        frame(16'h7fff, 16);
        // every range code shows up across the eight channels
        frame(mk_word(REG_RANGE_LOW, 8'h1b, 5'h00), 16);
        frame(mk_word(REG_RANGE_HIGH, 8'he4, 5'h00), 16);
        for (int i = 0; i < 8; i++)
            frame(mk_word(REG_CONTROL, 8'(i << 4), 5'((i % 2) * 6)), 16);
        // mid-run reset: channel 3 held code 11 before, must read 00 after
        rst <= 1'b1;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        model_reset();
        frame(mk_word(REG_CONTROL, 8'h30, 5'h00), 16);
        frame(16'h0000, 16);
        for (int k = 0; k < 3; k++)
        begin
            seqW = 8'($urandom_range(1, 255));
            frame(mk_word(REG_SEQUENCE, seqW, 5'h00), 16);
            frame(mk_word(REG_CONTROL, 8'h00, 5'h02), 16);
            repeat (10) frame(16'h0000, 16);
            frame(mk_word(REG_RANGE_LOW, 8'($urandom), 5'h00), 16);
            frame(mk_word(REG_RANGE_HIGH, 8'hff, 5'h00), 12);
            frame(mk_word(REG_CONTROL, 8'($urandom_range(0, 7) << 4), 5'h04), 16);
            repeat (10) frame(16'h0000, 16);
        end
        // random register traffic, tail zero except a control word's sequencer bits
        for (int k = 0; k < 20; k++)
        begin
            rsel = 2'($urandom);
            frame(mk_word(rsel, 8'($urandom), (rsel == REG_CONTROL) ? 5'($urandom) & 5'h06
                          : 5'h00), 16);
        end
        finish_test();
    end

    // about 110 frames of under 200 cycles each are expected
    initial
    begin
        repeat (60000) @(posedge mclk);
        nErrors++;
        finish_test();
    end
endmodule
